// ==== shared/pmas_pkg.sv ====
// Constants for the multiply with parallel sum and difference datapath
`default_nettype none
package pmas_pkg;
	// ==========================================
	// Widths
	localparam int unsigned WORD_W = 32; // Data word handled by the slice
	localparam int unsigned CF_W = 23; // Compute field width
	localparam int unsigned RA_W = 4; // Register-file address width
	localparam int unsigned SEL_W = 2; // Source selector width
	localparam int unsigned SRC_REGS = 16; // Entries that feed the sources
	// ==========================================
	// Compute field layout
	localparam int unsigned OPC_HI = 22;
	localparam int unsigned OPC_LO = 20;
	localparam int unsigned DIFF_DST_LO = 16;
	localparam int unsigned MUL_DST_LO = 12;
	localparam int unsigned SUM_DST_LO = 8;
	localparam int unsigned MUL_X_LO = 6;
	localparam int unsigned MUL_Y_LO = 4;
	localparam int unsigned ALU_X_LO = 2;
	localparam int unsigned ALU_Y_LO = 0;
	// ==========================================
	// Opcodes in the top three bits
	localparam logic [2:0] OPC_FIXED = 3'h6;
	localparam logic [2:0] OPC_FLOAT = 3'h7;
	// ==========================================
	// Source groups, upper address bits of each operand
	localparam logic [1:0] GRP_MUL_X = 2'h0;
	localparam logic [1:0] GRP_MUL_Y = 2'h1;
	localparam logic [1:0] GRP_ALU_X = 2'h2;
	localparam logic [1:0] GRP_ALU_Y = 2'h3;
	// ==========================================
	// Number formats
	localparam logic [63:0] FIX_RND = 64'h0000_0000_8000_0000; // Half an output lsb
	localparam logic [7:0] EXP_MAX = 8'hff; // Inf or NaN exponent
	localparam logic [7:0] EXP_ZERO = 8'h00; // Zero or denormal exponent
	localparam logic signed [9:0] EXP_BIAS = 10'sh07f;
	localparam logic signed [9:0] EXP_TOP = 10'sh0ff;
	localparam logic [31:0] FP_NAN = 32'hffff_ffff; // All ones answer
	localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
	localparam logic [4:0] MSUM_MSB = 5'h1b; // Top bit of adder sum
	localparam logic [7:0] ALIGN_MAX = 8'h1a; // Shift beyond which operand vanishes
endpackage
`default_nettype wire

// ==== shared/pmas_fp_if.sv ====
// Operand and result bundle between the core and a float adder
`timescale 1ns/1ps
`default_nettype none
interface pmas_fp_if;
	logic [31:0] op_a; // First addend
	logic [31:0] op_b; // Second addend, sign already set by the user
	logic [31:0] result; // Normalised sum
	modport user (output op_a, output op_b, input result);
	modport unit (input op_a, input op_b, output result);
endinterface
`default_nettype wire

// ==== verilog/pmas_fp_add.sv ====
// Single precision float adder, truncating, denormals flushed
`timescale 1ns/1ps
`default_nettype none
module pmas_fp_add (
	// Operands and result
	pmas_fp_if.unit fp
);
	import pmas_pkg::*;

	logic [31:0] big; // Operand with larger magnitude
	logic [31:0] sml; // Operand with smaller magnitude
	logic [26:0] m_big; // Hidden bit, fraction, three guard bits
	logic [26:0] m_sml;
	logic [26:0] m_shift; // Aligned smaller mantissa
	logic [7:0] e_diff; // Alignment distance
	logic [27:0] m_sum; // Raw sum with carry bit
	logic [27:0] m_norm; // Leading one at bit 26
	logic [4:0] lz; // Leading zeros of the raw sum
	logic signed [9:0] e_tmp; // Result exponent before range checks
	logic big_spec;
	logic sml_spec;

	// ==========================================
	// Alignment and add
	always_comb begin
		// Order by magnitude so one subtract never goes negative
		if (fp.op_a[30:0] >= fp.op_b[30:0]) begin
			big = fp.op_a;
			sml = fp.op_b;
		end else begin
			big = fp.op_b;
			sml = fp.op_a;
		end
		big_spec = (big[30:23] == EXP_MAX);
		sml_spec = (sml[30:23] == EXP_MAX);
		// Denormal inputs count as zero
		m_big = (big[30:23] == EXP_ZERO) ? 27'h0 : {1'b1, big[22:0], 3'h0};
		m_sml = (sml[30:23] == EXP_ZERO) ? 27'h0 : {1'b1, sml[22:0], 3'h0};
		e_diff = big[30:23] - sml[30:23];
		m_shift = (e_diff > ALIGN_MAX) ? 27'h0 : (m_sml >> e_diff);
		if (big[31] ^ sml[31]) begin
			m_sum = {1'b0, m_big} - {1'b0, m_shift};
		end else begin
			m_sum = {1'b0, m_big} + {1'b0, m_shift};
		end
	end

	// ==========================================
	// Normalise and pack
	always_comb begin
		// Highest set bit wins, so scan upward
		lz = 5'h0;
		for (int i = 0; i < 28; i++) begin
			if (m_sum[i]) begin
				lz = MSUM_MSB - 5'(i);
			end
		end
		// Carry out and plain cases share one exponent formula
		if (m_sum[27]) begin
			m_norm = m_sum >> 1;
		end else begin
			m_norm = m_sum << (lz - 5'h1);
		end
		e_tmp = $signed({2'b00, big[30:23]}) + 10'sd1 - $signed({5'h0, lz});
		if (big_spec && sml_spec) begin
			// Two specials collapse to the all ones answer
			fp.result = FP_NAN;
		end else if (big_spec) begin
			fp.result = big;
		end else if (m_sum == 28'h0 || e_tmp <= 10'sd0) begin
			// Cancellation and underflow both give zero
			fp.result = WORD_ZERO;
		end else if (e_tmp >= EXP_TOP) begin
			fp.result = {big[31], EXP_MAX, 23'h0};
		end else begin
			fp.result = {big[31], e_tmp[7:0], m_norm[25:3]};
		end
	end
endmodule // pmas_fp_add
`default_nettype wire

// ==== verilog/pmas_core.sv ====
// Multiply with parallel sum and difference, fixed and float forms
// Overview of operation
// - Multiply plus sum and difference per instruction
// - Multiplier sources from registers 0-3, 4-7
// - ALU sources from registers 8-11, 12-15
// - Each operand has its own source group
// - Product goes to multiplier destination register
// - Sum to sum dest, x minus y difference
// - Destinations may be any register
// - Opcode 110 selects fractional rounded fixed form
// - Opcode 111 selects floating-point form
// - Multiplier and ALU results land together
`timescale 1ns/1ps
`default_nettype none
module pmas_core (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic sys_rst,
	// Instruction from the decoder
	input wire logic instr_valid,
	input wire logic [pmas_pkg::CF_W-1:0] instr_field,
	// Register-file entries 0 to 15, entry n at bits n*32
	input wire logic [pmas_pkg::SRC_REGS*pmas_pkg::WORD_W-1:0] src_regs,
	// Multiplier result write port
	output logic mul_wr_en_ff,
	output logic [pmas_pkg::RA_W-1:0] mul_wr_addr_ff,
	output logic [pmas_pkg::WORD_W-1:0] mul_wr_data_ff,
	// Sum write port
	output logic sum_wr_en_ff,
	output logic [pmas_pkg::RA_W-1:0] sum_wr_addr_ff,
	output logic [pmas_pkg::WORD_W-1:0] sum_wr_data_ff,
	// Difference write port
	output logic diff_wr_en_ff,
	output logic [pmas_pkg::RA_W-1:0] diff_wr_addr_ff,
	output logic [pmas_pkg::WORD_W-1:0] diff_wr_data_ff
);
	import pmas_pkg::*;

	// ==========================================
	// Decode
	logic [2:0] opcode; // Form selector
	logic is_fixed; // Fractional fixed-point form
	logic is_float; // Floating-point form
	logic [RA_W-1:0] mul_result_dst; // Product destination
	logic [RA_W-1:0] sum_dst; // Sum destination
	logic [RA_W-1:0] diff_dst; // Difference destination
	logic [SEL_W-1:0] mul_x_src; // Selectors within each group
	logic [SEL_W-1:0] mul_y_src;
	logic [SEL_W-1:0] alu_x_src;
	logic [SEL_W-1:0] alu_y_src;

	// Field extraction
	always_comb begin
		opcode = instr_field[OPC_HI:OPC_LO];
		is_fixed = (opcode == OPC_FIXED);
		is_float = (opcode == OPC_FLOAT);
		// Full four bit destinations, no group limit
		diff_dst = instr_field[DIFF_DST_LO +: RA_W];
		mul_result_dst = instr_field[MUL_DST_LO +: RA_W];
		sum_dst = instr_field[SUM_DST_LO +: RA_W];
		mul_x_src = instr_field[MUL_X_LO +: SEL_W];
		mul_y_src = instr_field[MUL_Y_LO +: SEL_W];
		alu_x_src = instr_field[ALU_X_LO +: SEL_W];
		alu_y_src = instr_field[ALU_Y_LO +: SEL_W];
	end

	// ==========================================
	// Operand fetch
	logic [WORD_W-1:0] mul_x; // Multiplier x operand
	logic [WORD_W-1:0] mul_y; // Multiplier y operand
	logic [WORD_W-1:0] alu_x; // ALU x operand
	logic [WORD_W-1:0] alu_y; // ALU y operand

	// Group bits are fixed, so a selector can never reach another group
	always_comb begin
		mul_x = src_regs[{GRP_MUL_X, mul_x_src}*WORD_W +: WORD_W];
		mul_y = src_regs[{GRP_MUL_Y, mul_y_src}*WORD_W +: WORD_W];
		alu_x = src_regs[{GRP_ALU_X, alu_x_src}*WORD_W +: WORD_W];
		alu_y = src_regs[{GRP_ALU_Y, alu_y_src}*WORD_W +: WORD_W];
	end

	// ==========================================
	// Fixed-point arithmetic
	logic signed [63:0] fix_prod; // Full signed product
	logic [63:0] fix_rnd; // Fraction aligned and rounded
	logic [WORD_W-1:0] fix_mul; // Rounded fractional product
	logic [WORD_W-1:0] fix_sum;
	logic [WORD_W-1:0] fix_diff;

	// Signed fraction multiply, round to nearest at the output lsb
	always_comb begin
		fix_prod = $signed(mul_x) * $signed(mul_y);
		// Minus one squared wraps; no saturation in this slice
		fix_rnd = (fix_prod <<< 1) + FIX_RND;
		fix_mul = fix_rnd[63:32];
		fix_sum = alu_x + alu_y;
		fix_diff = alu_x - alu_y;
	end

	// ==========================================
	// Floating-point arithmetic
	logic [WORD_W-1:0] flt_mul; // Float product
	pmas_fp_if sum_bus (); // Adder for the sum
	pmas_fp_if diff_bus (); // Adder for the difference

	// Float multiply: truncating, denormals flushed, specials simplified
	function automatic logic [31:0] fp_mul(input logic [31:0] a, input logic [31:0] b);
		logic sgn;
		logic a_zero;
		logic b_zero;
		logic a_spec;
		logic b_spec;
		logic [47:0] prod;
		logic [22:0] frac;
		logic signed [9:0] e_res;
		sgn = a[31] ^ b[31];
		a_zero = (a[30:23] == EXP_ZERO);
		b_zero = (b[30:23] == EXP_ZERO);
		a_spec = (a[30:23] == EXP_MAX);
		b_spec = (b[30:23] == EXP_MAX);
		prod = {1'b1, a[22:0]} * {1'b1, b[22:0]};
		e_res = $signed({2'b00, a[30:23]}) + $signed({2'b00, b[30:23]}) - EXP_BIAS;
		// Product of two normals lies in [1,4)
		if (prod[47]) begin
			frac = prod[46:24];
			e_res = e_res + 10'sd1;
		end else begin
			frac = prod[45:23];
		end
		if ((a_spec || b_spec) && (a_zero || b_zero)) begin
			fp_mul = FP_NAN;
		end else if (a_spec || b_spec) begin
			fp_mul = {sgn, EXP_MAX, 23'h0};
		end else if (a_zero || b_zero || e_res <= 10'sd0) begin
			fp_mul = WORD_ZERO;
		end else if (e_res >= EXP_TOP) begin
			fp_mul = {sgn, EXP_MAX, 23'h0};
		end else begin
			fp_mul = {sgn, e_res[7:0], frac};
		end
	endfunction

	// Feed both adders at once; the difference flips the y sign
	always_comb begin
		flt_mul = fp_mul(mul_x, mul_y);
		sum_bus.op_a = alu_x;
		sum_bus.op_b = alu_y;
		diff_bus.op_a = alu_x;
		diff_bus.op_b = {~alu_y[31], alu_y[30:0]};
	end

	// Two copies so the sum and difference never share hardware
	pmas_fp_add u_sum_add (
		.fp (sum_bus.unit)
	);
	pmas_fp_add u_diff_add (
		.fp (diff_bus.unit)
	);

	// ==========================================
	// Result selection
	logic go; // Instruction belongs to this slice
	logic [WORD_W-1:0] nxt_mul_data;
	logic [WORD_W-1:0] nxt_sum_data;
	logic [WORD_W-1:0] nxt_diff_data;

	// Pick the form; other opcodes are not ours and write nothing
	always_comb begin
		go = instr_valid && (is_fixed || is_float);
		nxt_mul_data = is_float ? flt_mul : fix_mul;
		nxt_sum_data = is_float ? sum_bus.result : fix_sum;
		nxt_diff_data = is_float ? diff_bus.result : fix_diff;
	end

	// ==========================================
	// Write enables, all three raised in one cycle
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			mul_wr_en_ff <= 1'b0;
			sum_wr_en_ff <= 1'b0;
			diff_wr_en_ff <= 1'b0;
		end else begin
			mul_wr_en_ff <= go;
			sum_wr_en_ff <= go;
			diff_wr_en_ff <= go;
		end
	end

	// ==========================================
	// Destination addresses and data, held when idle
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			mul_wr_addr_ff <= 4'h0;
			sum_wr_addr_ff <= 4'h0;
			diff_wr_addr_ff <= 4'h0;
			mul_wr_data_ff <= WORD_ZERO;
			sum_wr_data_ff <= WORD_ZERO;
			diff_wr_data_ff <= WORD_ZERO;
		end else if (go) begin
			mul_wr_addr_ff <= mul_result_dst;
			sum_wr_addr_ff <= sum_dst;
			diff_wr_addr_ff <= diff_dst;
			mul_wr_data_ff <= nxt_mul_data;
			sum_wr_data_ff <= nxt_sum_data;
			diff_wr_data_ff <= nxt_diff_data;
		end
	end
endmodule // pmas_core
`default_nettype wire

// ==== dv/pmas_assertions.sv ====
// Checker for the multiply with parallel sum and difference datapath
`timescale 1ns/1ps
`default_nettype none
module pmas_assertions (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic sys_rst,
	// Instruction and sources
	input wire logic instr_valid,
	input wire logic [pmas_pkg::CF_W-1:0] instr_field,
	input wire logic [pmas_pkg::SRC_REGS*pmas_pkg::WORD_W-1:0] src_regs,
	// Write ports
	input wire logic mul_wr_en_ff,
	input wire logic [pmas_pkg::RA_W-1:0] mul_wr_addr_ff,
	input wire logic [pmas_pkg::WORD_W-1:0] mul_wr_data_ff,
	input wire logic sum_wr_en_ff,
	input wire logic [pmas_pkg::RA_W-1:0] sum_wr_addr_ff,
	input wire logic [pmas_pkg::WORD_W-1:0] sum_wr_data_ff,
	input wire logic diff_wr_en_ff,
	input wire logic [pmas_pkg::RA_W-1:0] diff_wr_addr_ff,
	input wire logic [pmas_pkg::WORD_W-1:0] diff_wr_data_ff
);
	import pmas_pkg::*;
	// ==========================================
	// Reference operands, each from its own group of four
	wire logic [31:0] mx = src_regs[32*{GRP_MUL_X, instr_field[7:6]} +: 32];
	wire logic [31:0] my = src_regs[32*{GRP_MUL_Y, instr_field[5:4]} +: 32];
	wire logic [31:0] ax = src_regs[32*{GRP_ALU_X, instr_field[3:2]} +: 32];
	wire logic [31:0] ay = src_regs[32*{GRP_ALU_Y, instr_field[1:0]} +: 32];
	wire logic [63:0] fp = (64'($signed(mx)) * 64'($signed(my)) << 1) + FIX_RND;
	wire logic [31:0] fmul = fp[63:32]; // Fractional product, rounded
	wire logic [31:0] fsum = ax + ay;
	wire logic [31:0] fdif = ax - ay;
	wire logic take = instr_valid && instr_field[22:21] == 2'h3; // Opcode 110 or 111
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	sequence s_fix;
		instr_valid && instr_field[22:20] == OPC_FIXED;
	endsequence
	sequence s_answer;
		mul_wr_en_ff && sum_wr_en_ff && diff_wr_en_ff;
	endsequence
	a_take_answer: assert property (take |=> s_answer)
		else $error("results missing after instruction");
	a_no_stray: assert property (mul_wr_en_ff |-> $past(take))
		else $error("result without instruction");
	a_refuse_hold: assert property (!take |=> !sum_wr_en_ff && $stable(mul_wr_data_ff))
		else $error("refused instruction changed outputs");
	a_mul_dst: assert property (take |=> mul_wr_addr_ff == $past(instr_field[15:12]))
		else $error("wrong product destination");
	a_sum_dst: assert property (take |=> sum_wr_addr_ff == $past(instr_field[11:8]))
		else $error("wrong sum destination");
	a_diff_dst: assert property (take |=> diff_wr_addr_ff == $past(instr_field[19:16]))
		else $error("wrong difference destination");
	a_fix_mul: assert property (s_fix |=> mul_wr_data_ff == $past(fmul))
		else $error("wrong fixed product");
	a_fix_sum: assert property (s_fix |=> sum_wr_data_ff == $past(fsum))
		else $error("wrong fixed sum");
	a_fix_diff: assert property (s_fix |=> diff_wr_data_ff == $past(fdif))
		else $error("wrong fixed difference");
endmodule // pmas_assertions
bind pmas_core pmas_assertions u_chk (.sys_clk, .sys_rst, .instr_valid, .instr_field, .src_regs,
	.mul_wr_en_ff, .mul_wr_addr_ff, .mul_wr_data_ff, .sum_wr_en_ff, .sum_wr_addr_ff,
	.sum_wr_data_ff, .diff_wr_en_ff, .diff_wr_addr_ff, .diff_wr_data_ff);
`default_nettype wire

// ==== dv/pmas_rf_model.sv ====
// Register-file model feeding the datapath sources
`timescale 1ns/1ps
`default_nettype none
module pmas_rf_model (
	// Combinational read of all sixteen entries
	output logic [pmas_pkg::SRC_REGS*pmas_pkg::WORD_W-1:0] src_regs
);
	import pmas_pkg::*;
	// ==========================================
	// Entries, loaded by the bench; write-back is left out to keep it small
	logic [WORD_W-1:0] regs [SRC_REGS];
	// Pack entry n at bits n*32
	always_comb begin
		for (int i = 0; i < SRC_REGS; i++) begin
			src_regs[i*WORD_W +: WORD_W] = regs[i];
		end
	end
endmodule // pmas_rf_model
`default_nettype wire

// ==== dv/parallel_mul_dual_addsub_tb.sv ====
// Self-checking bench for the multiply with parallel sum and difference
`timescale 1ns/1ps
`default_nettype none
module parallel_mul_dual_addsub_tb;
	import pmas_pkg::*;
	// ==========================================
	// Stimulus and observed signals
	logic sys_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic instr_valid = 1'b0;
	logic [CF_W-1:0] instr_field = '0;
	wire logic [SRC_REGS*WORD_W-1:0] src_regs;
	logic mul_wr_en_ff, sum_wr_en_ff, diff_wr_en_ff;
	logic [RA_W-1:0] mul_wr_addr_ff, sum_wr_addr_ff, diff_wr_addr_ff;
	logic [WORD_W-1:0] mul_wr_data_ff, sum_wr_data_ff, diff_wr_data_ff;
	int n_fail = 0;
	int samples_checked = 0;
	always #10 sys_clk = ~sys_clk; // 50 MHz
	pmas_core u_dut (.sys_clk, .sys_rst, .instr_valid, .instr_field, .src_regs,
		.mul_wr_en_ff, .mul_wr_addr_ff, .mul_wr_data_ff, .sum_wr_en_ff, .sum_wr_addr_ff,
		.sum_wr_data_ff, .diff_wr_en_ff, .diff_wr_addr_ff, .diff_wr_data_ff);
	pmas_rf_model u_rf (.src_regs);
	task automatic conclude;
		$display("comparisons %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// Fixed form reference: rounded fractional product, wrapping sum and difference
	function automatic logic [95:0] fx_exp(input logic [CF_W-1:0] f);
		logic [63:0] p;
		logic [31:0] ax, ay;
		p = 64'($signed(u_rf.regs[{2'h0, f[7:6]}])) * 64'($signed(u_rf.regs[{2'h1, f[5:4]}]));
		p = (p << 1) + 64'h0000_0000_8000_0000;
		ax = u_rf.regs[{2'h2, f[3:2]}];
		ay = u_rf.regs[{2'h3, f[1:0]}];
		return {p[63:32], ax + ay, ax - ay};
	endfunction
	task automatic issue(input logic [CF_W-1:0] f);
		@(posedge sys_clk);
		instr_valid <= 1'b1;
		instr_field <= f;
	endtask
	// All three results registered on the taking edge, checked just after it
	task automatic chk(input logic [CF_W-1:0] f, input logic [95:0] e);
		cmp({29'h0, mul_wr_en_ff, sum_wr_en_ff, diff_wr_en_ff}, 32'h7);
		cmp({20'h0, diff_wr_addr_ff, mul_wr_addr_ff, sum_wr_addr_ff}, {20'h0, f[19:8]});
		cmp(mul_wr_data_ff, e[95:64]);
		cmp(sum_wr_data_ff, e[63:32]);
		cmp(diff_wr_data_ff, e[31:0]);
	endtask
	task automatic run(input logic [CF_W-1:0] f, input logic [95:0] e);
		issue(f);
		@(posedge sys_clk);
		instr_valid <= 1'b0;
		#1;
		chk(f, e);
	endtask
	// Every selector value, wrap cases at selector zero
	task automatic t_fixed;
		logic [CF_W-1:0] f;
		for (int s = 0; s < 4; s++) begin
			f = {OPC_FIXED, 4'(s), 4'(s + 4), 4'(15 - s), 2'(s), 2'(3 - s), 2'(s), 2'(3 - s)};
			run(f, fx_exp(f));
		end
	endtask
	// Plain values, then infinity times zero with exact cancel
	task automatic t_float;
		run({OPC_FLOAT, 12'h037, 8'h55}, {32'h40c0_0000, 32'h3fc0_0000, 32'h3f00_0000});
		run({OPC_FLOAT, 12'h037, 8'haa}, {32'hffff_ffff, 32'h4000_0000, 32'h0000_0000});
	endtask
	// Other opcodes, and a valid opcode without valid, leave outputs alone
	task automatic t_refuse;
		logic [31:0] held;
		logic [31:0] held_sum;
		logic [31:0] held_diff;
		logic [11:0] held_dst;
		held = mul_wr_data_ff;
		held_sum = sum_wr_data_ff;
		held_diff = diff_wr_data_ff;
		held_dst = {diff_wr_addr_ff, mul_wr_addr_ff, sum_wr_addr_ff};
		for (int k = 0; k < 7; k++) begin
			@(posedge sys_clk);
			instr_valid <= (k < 6);
			instr_field <= {3'(k), 20'hfffff};
			@(posedge sys_clk);
			instr_valid <= 1'b0;
			#1;
			cmp({29'h0, mul_wr_en_ff, sum_wr_en_ff, diff_wr_en_ff}, 32'h0);
			cmp(mul_wr_data_ff, held);
			cmp(sum_wr_data_ff, held_sum);
			cmp(diff_wr_data_ff, held_diff);
			cmp(32'({diff_wr_addr_ff, mul_wr_addr_ff, sum_wr_addr_ff}), 32'(held_dst));
		end
	endtask
	// Two instructions on consecutive edges
	task automatic t_b2b;
		logic [95:0] e1, e2;
		e1 = fx_exp({OPC_FIXED, 20'h9ab1b});
		e2 = fx_exp({OPC_FIXED, 20'h321e4});
		issue({OPC_FIXED, 20'h9ab1b});
		issue({OPC_FIXED, 20'h321e4});
		#1;
		chk({OPC_FIXED, 20'h9ab1b}, e1);
		@(posedge sys_clk);
		instr_valid <= 1'b0;
		#1;
		chk({OPC_FIXED, 20'h321e4}, e2);
	endtask
	// ==========================================
	// Main sequence
	initial begin
		for (int i = 0; i < 16; i++) u_rf.regs[i] = 32'(i + 1) * 32'h1357_9bdf;
		u_rf.regs[0] = 32'h8000_0000;
		u_rf.regs[7] = 32'h8000_0000;
		u_rf.regs[8] = 32'h7fff_ffff;
		u_rf.regs[15] = 32'h0000_0001;
		{u_rf.regs[1], u_rf.regs[5], u_rf.regs[9], u_rf.regs[13]} =
			128'h40000000_40400000_3f800000_3f000000;
		{u_rf.regs[2], u_rf.regs[6], u_rf.regs[10], u_rf.regs[14]} =
			128'h7f800000_00000000_3f800000_3f800000;
		repeat (20) @(posedge sys_clk);
		sys_rst <= 1'b0;
		@(posedge sys_clk);
		#1;
		cmp({29'h0, mul_wr_en_ff, sum_wr_en_ff, diff_wr_en_ff}, 32'h0);
		cmp(32'({diff_wr_addr_ff, mul_wr_addr_ff, sum_wr_addr_ff}), 32'h0);
		cmp(mul_wr_data_ff | sum_wr_data_ff | diff_wr_data_ff, 32'h0);
		t_fixed();
		t_float();
		t_refuse();
		t_b2b();
		conclude();
	end
	// Tests need about 50 cycles; 1000 is ample margin
	initial begin
		#20us;
		n_fail++;
		conclude();
	end
endmodule // parallel_mul_dual_addsub_tb
`default_nettype wire
